//--- shared/prh_pkg.sv
// Package with register map, field positions and carrier types of the reference/holdover bank
package prh_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [7:0] REF_CTRL_OFS = 8'h1c;
    localparam logic [7:0] HOLD_CTRL_OFS = 8'h1d;
    localparam logic [7:0] STATUS_OFS = 8'h1f;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h21;
    // reference_input_control fields
    localparam int RC_DIFF = 0;
    localparam int RC_PRI_PWR = 1;
    localparam int RC_SEC_PWR = 2;
    localparam int RC_STAY_SEC = 3;
    localparam int RC_AUTO_SW = 4;
    // holdover_control fields
    localparam int HC_EN_LO = 0;
    localparam int HC_EXT = 1;
    localparam int HC_EN_HI = 2;
    localparam int HC_LDCMP = 3;
    localparam int HC_RDBK = 4;
    // pll_status_readback fields
    localparam int ST_LOCK = 0;
    localparam int ST_PRI_FREQ = 1;
    localparam int ST_SEC_FREQ = 2;
    localparam int ST_VCO_FREQ = 3;
    localparam int ST_SEC_SEL = 4;
    localparam int ST_HOLD = 5;
    localparam int ST_CAL = 6;
    // Interrupt event bits
    localparam int EV_LOCK_LOST = 0;
    localparam int EV_HOLD_IN = 1;
    localparam int EV_SWITCH = 2;
    localparam int EV_CAL_DONE = 3;
    localparam int EV_W = 4;
    // Reset values
    localparam logic [7:0] REF_CTRL_RST = 8'h00;
    localparam logic [7:0] HOLD_CTRL_RST = 8'h00;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // Raw analog-side status levels, all from outside the clock domain
    typedef struct packed {
        logic cal_done;
        logic vco_above;
        logic sec_above;
        logic pri_above;
        logic dig_lock;
        logic lock_detect_pin;
        logic hold_req_pin;
        logic pri_good;
        logic sec_good;
    } prh_stat_t;

    typedef struct packed {
        logic diff_mode;
        logic pri_pwr;
        logic sec_pwr;
        logic sec_selected;
        logic holdover_active;
        logic ldcmp_en;
    } prh_ctl_t;
endpackage : prh_pkg

//--- src/prh_sync.sv
// Two-flop synchroniser bank for the asynchronous status levels
`timescale 1ns/100ps
module prh_sync #(
    parameter int W = 9
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } prh_sync_st_t;

    prh_sync_st_t st_r;
    prh_sync_st_t st_nxt;

    initial begin
        if (W < 1) $error("prh_sync: W must be at least 1");
    end

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule : prh_sync

//--- src/prh_regs.sv
// Reference input, holdover control and PLL status register bank
//
// How it works
// - With stay-on-secondary set, a switch to secondary is never undone automatically.
// - Manual mode: secondary power bit powers the secondary input on or off.
// - Manual mode: primary power bit powers the primary input on or off.
// - Reference-mode bit: 0 single-ended, 1 differential.
// - Comparator enable 1: lock-detect pin level decides previous lock in auto holdover.
// - Comparator enable 0: auto holdover treats lock-detect pin as high.
// - Holdover works only when holdover bits 2 and 0 are both set.
// - External-holdover bit: 0 automatic controller, 1 hold-request pin decides.
// - Status bit 6 shows VCO calibration finished.
// - Status bit 5 shows the live holdover state.
// - Status bit 4 is 1 when secondary reference is selected.
// - Status bit 3 shows VCO frequency above threshold.
// - Status bit 2 shows secondary frequency above threshold.
// - Status bit 1 shows primary frequency above threshold.
// - Status bit 0 shows digital lock.
`timescale 1ns/100ps
module prh_regs #(
    parameter int SYNC_W = 9
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [prh_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [prh_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [prh_pkg::DATA_W-1:0] reg_rdata,
    input wire prh_pkg::prh_stat_t stat_in,
    output prh_pkg::prh_ctl_t ctl_out,
    output logic irq
);
    typedef struct packed {
        logic [7:0] ref_ctrl;
        logic [7:0] hold_ctrl;
        logic [prh_pkg::EV_W-1:0] irq_stat;
        logic [prh_pkg::EV_W-1:0] irq_mask;
        logic [7:0] rdata;
        logic sec_sel;
        logic hold_act;
        logic was_locked;
        logic lock_d;
        logic cal_d;
    } prh_st_t;

    prh_st_t st_r;
    prh_st_t st_nxt;
    prh_pkg::prh_stat_t ss;
    logic [prh_pkg::EV_W-1:0] ev;
    logic hold_en;
    logic ld_level;
    logic auto_sw;
    logic want_hold;
    logic [7:0] status_v;

    initial begin
        if (SYNC_W != $bits(prh_pkg::prh_stat_t)) $error("prh_regs: SYNC_W mismatch");
    end

    // Every status level arrives from the analog side and is synchronised first
    prh_sync #(.W(SYNC_W)) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d(stat_in),
        .q(ss)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    always_comb begin
        hold_en = st_r.hold_ctrl[prh_pkg::HC_EN_HI] & st_r.hold_ctrl[prh_pkg::HC_EN_LO];
        auto_sw = st_r.ref_ctrl[prh_pkg::RC_AUTO_SW] & ~st_r.ref_ctrl[prh_pkg::RC_DIFF];
        // Disabled comparator reads as a permanently high pin
        ld_level = st_r.hold_ctrl[prh_pkg::HC_LDCMP] ? ss.lock_detect_pin : 1'b1;
        if (st_r.hold_ctrl[prh_pkg::HC_EXT]) begin
            want_hold = ss.hold_req_pin;
        end else begin
            // Hold only if the loop had been locked and the selected input went bad
            want_hold = st_r.was_locked & ld_level
                & ~(st_r.sec_sel ? ss.sec_good : ss.pri_good);
        end
        status_v = '0;
        status_v[prh_pkg::ST_CAL] = ss.cal_done;
        status_v[prh_pkg::ST_HOLD] = st_r.hold_act;
        status_v[prh_pkg::ST_SEC_SEL] = st_r.sec_sel;
        status_v[prh_pkg::ST_VCO_FREQ] = ss.vco_above;
        status_v[prh_pkg::ST_SEC_FREQ] = ss.sec_above;
        status_v[prh_pkg::ST_PRI_FREQ] = ss.pri_above;
        status_v[prh_pkg::ST_LOCK] = ss.dig_lock;

        st_nxt = st_r;
        st_nxt.lock_d = ss.dig_lock;
        st_nxt.cal_d = ss.cal_done;
        if (ss.dig_lock) begin
            st_nxt.was_locked = 1'b1;
        end
        st_nxt.hold_act = hold_en & want_hold;
        if (!hold_en) begin
            st_nxt.was_locked = ss.dig_lock;
        end

        // Reference selection
        if (st_r.ref_ctrl[prh_pkg::RC_DIFF]) begin
            st_nxt.sec_sel = 1'b0;
        end else if (auto_sw) begin
            if (!st_r.sec_sel && !ss.pri_good && ss.sec_good) begin
                st_nxt.sec_sel = 1'b1;
            end else if (st_r.sec_sel && ss.pri_good && !ss.sec_good
                && !st_r.ref_ctrl[prh_pkg::RC_STAY_SEC]) begin
                // Back to primary only when not pinned to secondary
                st_nxt.sec_sel = 1'b0;
            end else if (st_r.sec_sel && ss.pri_good
                && !st_r.ref_ctrl[prh_pkg::RC_STAY_SEC]) begin
                st_nxt.sec_sel = 1'b0;
            end
        end else begin
            st_nxt.sec_sel = 1'b0;
        end

        ev = '0;
        ev[prh_pkg::EV_LOCK_LOST] = st_r.lock_d & ~ss.dig_lock;
        ev[prh_pkg::EV_HOLD_IN] = ~st_r.hold_act & st_nxt.hold_act;
        ev[prh_pkg::EV_SWITCH] = st_r.sec_sel ^ st_nxt.sec_sel;
        ev[prh_pkg::EV_CAL_DONE] = ~st_r.cal_d & ss.cal_done;

        // Register writes; new events win over a write-one clear
        st_nxt.irq_stat = st_r.irq_stat;
        if (reg_wr) begin
            if (hit(reg_addr, prh_pkg::REF_CTRL_OFS)) begin
                st_nxt.ref_ctrl = reg_wdata;
            end
            if (hit(reg_addr, prh_pkg::HOLD_CTRL_OFS)) begin
                st_nxt.hold_ctrl = reg_wdata;
            end
            if (hit(reg_addr, prh_pkg::IRQ_STAT_OFS)) begin
                st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata[prh_pkg::EV_W-1:0];
            end
            if (hit(reg_addr, prh_pkg::IRQ_MASK_OFS)) begin
                st_nxt.irq_mask = reg_wdata[prh_pkg::EV_W-1:0];
            end
        end
        st_nxt.irq_stat = st_nxt.irq_stat | ev;

        // Read data valid the cycle after the strobe; unmapped reads give zero
        st_nxt.rdata = '0;
        if (reg_rd) begin
            if (hit(reg_addr, prh_pkg::REF_CTRL_OFS)) begin
                st_nxt.rdata = st_r.ref_ctrl;
            end else if (hit(reg_addr, prh_pkg::HOLD_CTRL_OFS)) begin
                st_nxt.rdata = st_r.hold_ctrl;
            end else if (hit(reg_addr, prh_pkg::STATUS_OFS)) begin
                st_nxt.rdata = st_r.hold_ctrl[prh_pkg::HC_RDBK] ? status_v : 8'h00;
            end else if (hit(reg_addr, prh_pkg::IRQ_STAT_OFS)) begin
                st_nxt.rdata = {4'h0, st_r.irq_stat};
            end else if (hit(reg_addr, prh_pkg::IRQ_MASK_OFS)) begin
                st_nxt.rdata = {4'h0, st_r.irq_mask};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.ref_ctrl <= prh_pkg::REF_CTRL_RST;
            st_r.hold_ctrl <= prh_pkg::HOLD_CTRL_RST;
            st_r.irq_mask <= prh_pkg::IRQ_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        ctl_out.diff_mode = st_r.ref_ctrl[prh_pkg::RC_DIFF];
        // Automatic mode powers both inputs so either can be switched to
        if (auto_sw) begin
            ctl_out.pri_pwr = 1'b1;
            ctl_out.sec_pwr = 1'b1;
        end else begin
            ctl_out.pri_pwr = st_r.ref_ctrl[prh_pkg::RC_PRI_PWR];
            ctl_out.sec_pwr = st_r.ref_ctrl[prh_pkg::RC_SEC_PWR];
        end
        ctl_out.sec_selected = st_r.sec_sel;
        ctl_out.holdover_active = st_r.hold_act;
        ctl_out.ldcmp_en = st_r.hold_ctrl[prh_pkg::HC_LDCMP];
    end

    assign reg_rdata = st_r.rdata;
    assign irq = |(st_r.irq_stat & st_r.irq_mask);
endmodule : prh_regs

//--- dv/prh_regs_properties.sv
// Port-level properties of the reference and holdover register bank
`timescale 1ns/100ps
module prh_regs_props (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire prh_pkg::prh_stat_t stat_in,
    input wire prh_pkg::prh_ctl_t ctl_out,
    input wire logic irq
);
    // Shadows rebuilt from observed writes, so no internal signal is needed
    logic [7:0] hc_r;
    logic [7:0] rc_r;
    logic [7:0] mk_r;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hc_r <= 8'h00;
            rc_r <= 8'h00;
            mk_r <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 8'h1d) hc_r <= reg_wdata;
            if (reg_addr == 8'h1c) rc_r <= reg_wdata;
            if (reg_addr == 8'h21) mk_r <= reg_wdata;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    unmapped_rd_a: assert property (reg_rd && !(reg_addr inside {8'h1c, 8'h1d, 8'h1f,
        8'h20, 8'h21}) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    status_gate_a: assert property (reg_rd && reg_addr == 8'h1f && !hc_r[4] |=>
        reg_rdata == 8'h00) else $error("status read while gated");
    diff_sel_a: assert property (ctl_out.diff_mode [*2] |-> !ctl_out.sec_selected)
        else $error("secondary selected in differential mode");
    manual_pwr_a: assert property (!rc_r[4] |-> ctl_out.pri_pwr == rc_r[1] &&
        ctl_out.sec_pwr == rc_r[2]) else $error("manual power mismatch");
    auto_pwr_a: assert property (rc_r[4] && !rc_r[0] |-> ctl_out.pri_pwr && ctl_out.sec_pwr)
        else $error("auto switchover power off");
    hold_off_a: assert property ((!(hc_r[2] && hc_r[0])) [*3] |->
        !ctl_out.holdover_active) else $error("holdover while disabled");
    irq_mask_a: assert property (mk_r[3:0] == 4'h0 |-> !irq)
        else $error("interrupt with all masked");
endmodule : prh_regs_props

bind prh_regs prh_regs_props i_prh_regs_props (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stat_in(stat_in), .ctl_out(ctl_out), .irq(irq));

//--- dv/testbench.sv
// Self-checking bench for the reference and holdover register bank
`timescale 1ns/100ps
module testbench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    prh_pkg::prh_stat_t stat_in = '0;
    prh_pkg::prh_ctl_t ctl_out;
    logic irq;
    int mismatches = 0;
    int n_checks = 0;
    logic [4:0] pats [4] = '{5'h15, 5'h0a, 5'h1f, 5'h00};
    prh_regs i_prh_regs (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .stat_in(stat_in), .ctl_out(ctl_out), .irq(irq));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("rd %h", a), e, reg_rdata & m);
    endtask : rd
    // Covers the two synchroniser flops plus the state register behind them
    task automatic st();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : st
    task automatic hold_is(input logic e);
        st();
        chk("holdover_active", {7'h0, e}, {7'h0, ctl_out.holdover_active});
        rd(8'h1f, 8'h20, {2'h0, e, 5'h0});
    endtask : hold_is
    task automatic tally_and_finish();
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (8) @(posedge ref_clk);
        chk("ctl_out", 8'h00, {2'h0, ctl_out});
        rstn <= 1'b1;
        rd(8'h1c, 8'hff, 8'h00);
        rd(8'h1d, 8'hff, 8'h00);
        rd(8'h21, 8'hff, 8'h00);
        rd(8'h1e, 8'hff, 8'h00);
        for (int v = 0; v < 8; v++) begin
            wr(8'h1c, 8'(v));
            chk("pwr", 8'(v), {5'h0, ctl_out.sec_pwr, ctl_out.pri_pwr, ctl_out.diff_mode});
            rd(8'h1c, 8'hff, 8'(v));
        end
        wr(8'h1c, 8'h00);
        @(posedge ref_clk) stat_in <= '1;
        st();
        rd(8'h1f, 8'hff, 8'h00);
        wr(8'h1d, 8'h10);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) stat_in[8:4] <= pats[i];
            st();
            rd(8'h1f, 8'h4f, {1'b0, pats[i][4], 2'h0, pats[i][3:0]});
        end
        @(posedge ref_clk) stat_in <= 9'h006;
        wr(8'h1d, 8'h13);
        hold_is(1'b0);
        wr(8'h1d, 8'h17);
        hold_is(1'b1);
        @(posedge ref_clk) stat_in.hold_req_pin <= 1'b0;
        hold_is(1'b0);
        @(posedge ref_clk) stat_in.hold_req_pin <= 1'b1;
        wr(8'h1d, 8'h16);
        hold_is(1'b0);
        @(posedge ref_clk) stat_in <= 9'h012;
        wr(8'h1d, 8'h15);
        hold_is(1'b0);
        @(posedge ref_clk) stat_in.pri_good <= 1'b0;
        hold_is(1'b1);
        wr(8'h1d, 8'h1d);
        chk("ldcmp_en", 8'h01, {7'h0, ctl_out.ldcmp_en});
        hold_is(1'b0);
        @(posedge ref_clk) stat_in.lock_detect_pin <= 1'b1;
        hold_is(1'b1);
        wr(8'h1d, 8'h10);
        @(posedge ref_clk) stat_in <= 9'h001;
        wr(8'h1c, 8'h18);
        // Automatic switchover must power both inputs whatever the manual bits say
        chk("pwr", 8'h06, {5'h0, ctl_out.sec_pwr, ctl_out.pri_pwr, ctl_out.diff_mode});
        st();
        rd(8'h1f, 8'h10, 8'h10);
        @(posedge ref_clk) stat_in.pri_good <= 1'b1;
        st();
        rd(8'h1f, 8'h10, 8'h10);
        wr(8'h1c, 8'h10);
        st();
        rd(8'h1f, 8'h10, 8'h00);
        @(posedge ref_clk) stat_in.pri_good <= 1'b0;
        st();
        rd(8'h1f, 8'h10, 8'h10);
        wr(8'h1c, 8'h11);
        st();
        rd(8'h1f, 8'h10, 8'h00);
        // Lock loss, holdover entry, switch and calibration have all happened by now
        rd(8'h20, 8'hff, 8'h0f);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'hff, 8'h00);
        wr(8'h21, 8'hff);
        rd(8'h21, 8'hff, 8'h0f);
        @(posedge ref_clk) stat_in.dig_lock <= 1'b1;
        st();
        @(posedge ref_clk) stat_in.dig_lock <= 1'b0;
        st();
        rd(8'h20, 8'h01, 8'h01);
        chk("irq", 8'h01, {7'h0, irq});
        wr(8'h21, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        wr(8'h21, 8'h01);
        chk("irq", 8'h01, {7'h0, irq});
        wr(8'h20, 8'h01);
        chk("irq", 8'h00, {7'h0, irq});
        tally_and_finish();
    end
endmodule : testbench
